/* File: src/hbi_top.sv */
// Purpose: Host parallel bus port with strobe and bus style detection.
// Assumes: Host pins synchronous to clock_in; one clock domain.
// Notes: Rules follow, one line each.
// Contract
// R1: Refused enquiry sends alert then code 15H
// R2: Alert is six mark units; line idles space
// R3: Eight-bit data bus with address and control
// R4: Detect strobe style from host write activity
// R5: Host writes external memory before first access
// R6: Assume separate read/write strobes until detected
// R7: Host writes then reads odd location first
// R8: Lowest address activity means non-multiplexed bus
// R9: Assume multiplexed bus before any evidence
// R10: Odd write then read settles both modes
// R11: Select with read freezes modes until reset
// R12: Registers direct decoded; RAM via pointer only
// R13: No wait states; RAM arbitrated internally
// R14: Pointer auto-increment or fixed mode
// R15: Loading read pointer prefetches RAM byte
// R16: Data read alone does not refetch RAM
// R17: Data write held then committed to RAM
// R18: Reading diagnostic status clears it
// R19: Fast read samples select lines on delayed strobe
// R20: Internal read ends on undelayed strobe rise
// R21: Read data path uses unsampled undelayed signals
// R22: Delayed sampled read drives read pulses
// R23: Delays about 15 ns then 10 ns; code uses one 40 ns clock cycle for each
// R24: Fast-read select: 0 normal, 1 fast reads
// R25: Same delaying in direction plus strobe style
// R26: Host should stretch reads in fast mode
// R27: Delays built as clocked register stages
`timescale 1ns/10ps
`default_nettype none
module hbi_top (
   input wire logic clock_in, // System clock
   input wire logic rst_in, // Async reset, active high
   input wire logic chip_sel_low_in, // Chip select, active low
   input wire logic read_strobe_low_in, // Read strobe, or direction (1 = read)
   input wire logic write_strobe_low_in, // Write strobe, active low
   input wire logic data_strobe_low_in, // Data strobe, active low
   input wire logic lowest_address_line_in, // Lowest address bit
   input wire logic [2:0] register_select_lines_in, // Register select
   input wire logic [hbi_pkg::DATA_W-1:0] data_in, // Host data in
   output logic [hbi_pkg::DATA_W-1:0] data_out, // Host read data
   output logic data_oe_out, // Data bus drive enable
   input wire logic fast_read_select_in, // 1 = high-speed read
   input wire logic [7:0] diagnostic_status_event_in, // Diagnostic event bits
   input wire logic [7:0] next_node_in, // Next node value
   input wire logic nak_request_in, // Refuse enquiry, one pulse
   output logic line_tx_out, // Line output, 1 = mark
   output logic nak_busy_out, // Frame in progress
   output logic strobe_is_dir_out, // 1 = direction plus data strobe
   output logic bus_is_nonmux_out, // 1 = non-multiplexed bus
   output logic modes_frozen_out // Modes locked
);
   import hbi_pkg::*;
   // ************************************************************
   // Mode detection
   // ************************************************************
   logic strobe_is_dir, next_strobe_is_dir; // Detected strobe style
   logic bus_is_nonmux, next_bus_is_nonmux; // Detected bus style
   logic frozen, next_frozen; // Modes locked
   logic wr_seen, next_wr_seen; // Host write activity observed
   logic sel_active; // Chip select asserted
   logic dir_read; // Read access in either style
   logic dir_write; // Write access in either style
   assign sel_active = !chip_sel_low_in;
   // Until detected, separate strobes are assumed
   assign dir_read = strobe_is_dir ? (!data_strobe_low_in && read_strobe_low_in)
                                   : !read_strobe_low_in; // R6 R25
   assign dir_write = strobe_is_dir ? (!data_strobe_low_in && !read_strobe_low_in)
                                    : !write_strobe_low_in;
   // Next mode values
   always_comb begin
      next_strobe_is_dir = strobe_is_dir;
      next_bus_is_nonmux = bus_is_nonmux;
      next_frozen = frozen;
      next_wr_seen = wr_seen;
      if (!frozen) begin
         // Write strobe idle while data strobe pulses means direction style
         if (!write_strobe_low_in) begin
            next_wr_seen = 1'b1; // R4
            next_strobe_is_dir = 1'b0;
         end else if (!data_strobe_low_in && !wr_seen) begin
            next_strobe_is_dir = 1'b1; // R4
         end
         // Odd address seen on a strobe means address is not muxed
         if ((dir_write || dir_read) && lowest_address_line_in) begin
            next_bus_is_nonmux = 1'b1; // R8 R10
         end
         if (sel_active && dir_read) begin
            next_frozen = 1'b1; // R11
         end
      end
   end
   // Mode registers
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         strobe_is_dir <= 1'b0; // R6
         bus_is_nonmux <= 1'b0; // R9
         frozen <= 1'b0;
         wr_seen <= 1'b0;
      end else begin
         strobe_is_dir <= next_strobe_is_dir;
         bus_is_nonmux <= next_bus_is_nonmux;
         frozen <= next_frozen;
         wr_seen <= next_wr_seen;
      end
   end
   assign strobe_is_dir_out = strobe_is_dir;
   assign bus_is_nonmux_out = bus_is_nonmux;
   assign modes_frozen_out = frozen;
   // ************************************************************
   // Read strobe delay and sampling
   // ************************************************************
   localparam int DLY_LEN = DELAY1_CYCLES + DELAY2_CYCLES;
   logic [DLY_LEN-1:0] rd_dly, next_rd_dly; // Delay line of read level
   logic [2:0] samp_sel, next_samp_sel; // Sampled register select
   logic samp_cs, next_samp_cs; // Sampled chip select
   logic rd_first; // First delayed read
   logic rd_second; // Second delayed read
   logic rd_int; // Internal read level
   logic rd_int_q, next_rd_int_q; // Previous internal read
   logic rd_pulse; // One-cycle read start pulse
   logic [2:0] eff_sel; // Select used for pulses
   logic eff_cs; // Chip select used for pulses
   assign rd_first = rd_dly[DELAY1_CYCLES-1]; // R23
   assign rd_second = rd_dly[DLY_LEN-1]; // R23
   // Shift read level; capture address at first delayed edge
   always_comb begin
      next_rd_dly = {rd_dly[DLY_LEN-2:0], dir_read}; // R27
      if (!dir_read) begin
         next_rd_dly = '0; // R20
      end
      next_samp_sel = samp_sel;
      next_samp_cs = samp_cs;
      if (dir_read && !rd_first && next_rd_dly[DELAY1_CYCLES-1]) begin
         next_samp_sel = register_select_lines_in; // R19
         next_samp_cs = sel_active; // R19
      end
      next_rd_int_q = rd_int;
   end
   // Fast mode uses delayed start, undelayed end
   assign rd_int = fast_read_select_in ? (rd_second && dir_read) : dir_read; // R24 R20
   assign eff_sel = fast_read_select_in ? samp_sel : register_select_lines_in; // R22
   assign eff_cs = fast_read_select_in ? samp_cs : sel_active; // R22
   assign rd_pulse = rd_int && !rd_int_q && eff_cs; // R22
   // Delay registers
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         rd_dly <= '0;
         samp_sel <= 3'h0;
         samp_cs <= 1'b0;
         rd_int_q <= 1'b0;
      end else begin
         rd_dly <= next_rd_dly;
         samp_sel <= next_samp_sel;
         samp_cs <= next_samp_cs;
         rd_int_q <= next_rd_int_q;
      end
   end
   // ************************************************************
   // Registers and RAM
   // ************************************************************
   logic [7:0] ram [RAM_DEPTH]; // Buffer RAM
   logic [10:0] ptr, next_ptr; // RAM address pointer
   logic ptr_read, next_ptr_read; // Pointer loaded for reads
   logic ptr_inc, next_ptr_inc; // Auto-increment enable
   logic [7:0] data_reg, next_data_reg; // Data register
   logic [7:0] diagnostic_status, next_diagnostic_status; // Diagnostic status
   logic wr_commit, next_wr_commit; // Pending RAM write
   logic prefetch, next_prefetch; // Pending RAM fetch
   logic wr_q, next_wr_q; // Previous write level
   logic wr_pulse; // Write start pulse
   assign wr_pulse = dir_write && !wr_q && sel_active; // R3
   // Pointer increment helper
   function automatic logic [10:0] ptr_step(input logic [10:0] p, input logic inc);
      ptr_step = inc ? p + 11'h001 : p; // R14
   endfunction : ptr_step
   // Next register values
   always_comb begin
      next_ptr = ptr;
      next_ptr_read = ptr_read;
      next_ptr_inc = ptr_inc;
      next_data_reg = data_reg;
      next_diagnostic_status = diagnostic_status | diagnostic_status_event_in;
      next_wr_commit = 1'b0;
      next_prefetch = 1'b0;
      next_wr_q = dir_write;
      if (wr_pulse) begin
         case (register_select_lines_in) // R12
            REG_PTR_HI: begin
               next_ptr = {data_in[2:0], ptr[7:0]};
               next_ptr_read = data_in[PTR_HI_READ_BIT];
               next_ptr_inc = data_in[PTR_HI_AUTOINC_BIT];
            end
            REG_PTR_LO: begin
               next_ptr = {ptr[10:8], data_in};
               next_prefetch = ptr_read; // R15
            end
            REG_DATA: begin
               next_data_reg = data_in; // R17
               next_wr_commit = 1'b1; // R17
            end
            default: begin
               next_ptr = ptr;
            end
         endcase
      end
      if (wr_commit) begin
         next_ptr = ptr_step(ptr, ptr_inc); // R14
      end
      if (prefetch) begin
         next_data_reg = ram[ptr]; // R15 R13
      end
      if (rd_pulse && eff_sel == REG_DATA) begin
         next_ptr = ptr_step(ptr, ptr_inc); // R16
      end
      if (rd_int_q && !rd_int && samp_cs && samp_sel == REG_DIAGNOSTIC_STATUS) begin // After data shown
         next_diagnostic_status = diagnostic_status_event_in; // R18 R22
      end
   end
   // Register file and RAM port
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         ptr <= PTR_RESET;
         ptr_read <= 1'b0;
         ptr_inc <= 1'b0;
         data_reg <= DATA_RESET;
         diagnostic_status <= DIAGNOSTIC_STATUS_RESET;
         wr_commit <= 1'b0;
         prefetch <= 1'b0;
         wr_q <= 1'b0;
      end else begin
         ptr <= next_ptr;
         ptr_read <= next_ptr_read;
         ptr_inc <= next_ptr_inc;
         data_reg <= next_data_reg;
         diagnostic_status <= next_diagnostic_status;
         wr_commit <= next_wr_commit;
         prefetch <= next_prefetch;
         wr_q <= next_wr_q;
      end
   end
   // RAM write, no reset on storage
   always_ff @(posedge clock_in) begin
      if (wr_commit) begin
         ram[ptr] <= data_reg; // R17
      end
   end
   // ************************************************************
   // Read data output
   // ************************************************************
   logic [7:0] rdata, next_rdata; // Registered read data
   // Unsampled address and undelayed strobe
   always_comb begin
      case (register_select_lines_in) // R21
         REG_DIAGNOSTIC_STATUS: next_rdata = diagnostic_status;
         REG_PTR_HI: next_rdata = {ptr_read, ptr_inc, 3'h0, ptr[10:8]};
         REG_PTR_LO: next_rdata = ptr[7:0];
         REG_DATA: next_rdata = data_reg;
         REG_NEXT_NODE: next_rdata = next_node_in;
         default: next_rdata = 8'h00;
      endcase
   end
   // Read data register
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         rdata <= 8'h00;
      end else begin
         rdata <= next_rdata;
      end
   end
   assign data_out = rdata;
   assign data_oe_out = sel_active && dir_read; // R21
   // ************************************************************
   // Negative acknowledge frame sender
   // ************************************************************
   hbi_nak_e nak_state, next_nak_state; // Sender state
   logic [4:0] unit_idx, next_unit_idx; // Unit interval index
   logic [2:0] cyc, next_cyc; // Cycle within unit
   logic tx, next_tx; // Line level
   logic [10:0] frame_bits; // Start mark, mark, space, then data
   // Character: two mark, one space, eight data bits msb first
   assign frame_bits = {2'b11, 1'b0, NAK_CODE}; // R1
   // Next sender values
   always_comb begin
      next_nak_state = nak_state;
      next_unit_idx = unit_idx;
      next_cyc = cyc;
      next_tx = 1'b0; // R2
      case (nak_state)
         NAK_IDLE: begin
            if (nak_request_in) begin
               next_nak_state = NAK_SEND;
               next_unit_idx = 5'h00;
               next_cyc = 3'h0;
               next_tx = 1'b1;
            end
         end
         NAK_SEND: begin
            if (cyc == 3'(UNIT_CYCLES - 1)) begin
               next_cyc = 3'h0;
               next_unit_idx = unit_idx + 5'h01;
            end else begin
               next_cyc = cyc + 3'h1;
            end
            if (next_unit_idx == 5'(FRAME_UNITS)) begin
               next_nak_state = NAK_IDLE;
               next_tx = 1'b0;
            end else if (next_unit_idx < 5'(ALERT_UNITS)) begin
               next_tx = 1'b1; // R2
            end else begin
               next_tx = frame_bits[4'(5'(FRAME_UNITS - 1) - next_unit_idx)]; // R1
            end
         end
         default: begin
            next_nak_state = NAK_IDLE;
         end
      endcase
   end
   // Sender registers
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         nak_state <= NAK_IDLE;
         unit_idx <= 5'h00;
         cyc <= 3'h0;
         tx <= 1'b0;
      end else begin
         nak_state <= next_nak_state;
         unit_idx <= next_unit_idx;
         cyc <= next_cyc;
         tx <= next_tx;
      end
   end
   assign line_tx_out = tx;
   assign nak_busy_out = (nak_state == NAK_SEND);
endmodule : hbi_top
`default_nettype wire

/* File: src/hbi_pkg.sv */
// Purpose: Constants and types for the host bus port with mode detection.
// Assumes: 25 MHz clock, host strobes taken as synchronous inputs.
// Notes: Register offsets are local choices; see top module.
package hbi_pkg;
   // ************************************************************
   // Sizes
   // ************************************************************
   localparam int DATA_W = 8;
   localparam int SEL_W = 3;
   localparam int RAM_AW = 11;
   localparam int RAM_DEPTH = 2048;
   // ************************************************************
   // Register select codes
   // ************************************************************
   localparam logic [2:0] REG_DIAGNOSTIC_STATUS = 3'h1;
   localparam logic [2:0] REG_PTR_HI = 3'h2;
   localparam logic [2:0] REG_PTR_LO = 3'h3;
   localparam logic [2:0] REG_DATA = 3'h4;
   localparam logic [2:0] REG_NEXT_NODE = 3'h7;
   // Pointer high byte fields
   localparam int PTR_HI_READ_BIT = 7;
   localparam int PTR_HI_AUTOINC_BIT = 6;
   // ************************************************************
   // Reset values
   // ************************************************************
   localparam logic [7:0] DIAGNOSTIC_STATUS_RESET = 8'h00;
   localparam logic [10:0] PTR_RESET = 11'h000;
   localparam logic [7:0] DATA_RESET = 8'h00;
   localparam logic [7:0] NEXT_NODE_RESET = 8'h00;
   // ************************************************************
   // Line frame constants
   // ************************************************************
   localparam logic [7:0] NAK_CODE = 8'h15;
   localparam int ALERT_UNITS = 6;
   localparam int CHAR_UNITS = 11;
   localparam int UNIT_NS = 200;
   localparam int CLOCK_MHZ = 25;
   localparam int UNIT_CYCLES = (UNIT_NS * CLOCK_MHZ + 999) / 1000;
   localparam int FRAME_UNITS = ALERT_UNITS + CHAR_UNITS;
   // ************************************************************
   // Read strobe delays
   // ************************************************************
   localparam int DELAY1_NS = 15;
   localparam int DELAY2_NS = 10;
   localparam int DELAY1_CYCLES = (DELAY1_NS * CLOCK_MHZ + 999) / 1000;
   localparam int DELAY2_CYCLES = (DELAY2_NS * CLOCK_MHZ + 999) / 1000;
   // Frame sender states
   typedef enum logic [1:0] {NAK_IDLE, NAK_SEND} hbi_nak_e;
endpackage : hbi_pkg

/* File: tb/hbi_top_props.sv */
// Purpose: Concurrent checks on the pins of the host bus port.
// Assumes: One clock domain, asynchronous reset active high.
// Notes: Bound to the top module from the testbench top file.
`timescale 1ns/10ps
`default_nettype none
module hbi_top_props
   import hbi_pkg::*;
(
   input wire logic clock_in, // Clock
   input wire logic rst_in, // Reset
   input wire logic chip_sel_low_in, // Select
   input wire logic read_strobe_low_in, // Read or direction
   input wire logic write_strobe_low_in, // Write
   input wire logic data_strobe_low_in, // Data strobe
   input wire logic lowest_address_line_in, // Address bit 0
   input wire logic [2:0] register_select_lines_in, // Select lines
   input wire logic [7:0] data_in, // Write data
   input wire logic [7:0] data_out, // Read data
   input wire logic data_oe_out, // Drive enable
   input wire logic fast_read_select_in, // Fast read
   input wire logic [7:0] diagnostic_status_event_in, // Events
   input wire logic [7:0] next_node_in, // Next node
   input wire logic nak_request_in, // Frame request
   input wire logic line_tx_out, // Line
   input wire logic nak_busy_out, // Frame busy
   input wire logic strobe_is_dir_out, // Strobe style
   input wire logic bus_is_nonmux_out, // Bus style
   input wire logic modes_frozen_out // Modes locked
);
   // ************************************************************
   // Run counters for the line frame
   // ************************************************************
   logic [7:0] ones_run; // Mark cycles in a row
   logic [7:0] busy_run; // Busy cycles in a row
   logic [7:0] next_ones_run; // Next mark count
   logic [7:0] next_busy_run; // Next busy count
   // Count runs so lengths are known when they end
   always_comb begin
      next_ones_run = line_tx_out ? ones_run + 8'h01 : 8'h00;
      next_busy_run = nak_busy_out ? busy_run + 8'h01 : 8'h00;
   end
   // Register the counts
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         ones_run <= 8'h00;
         busy_run <= 8'h00;
      end else begin
         ones_run <= next_ones_run;
         busy_run <= next_busy_run;
      end
   end
   default clocking cb @(posedge clock_in);
   endclocking
   default disable iff (rst_in);
   modes_held_a:
      assert property (modes_frozen_out |=> modes_frozen_out && $stable(strobe_is_dir_out)
         && $stable(bus_is_nonmux_out)) else $error("modes changed after lock");
   freeze_on_read_a:
      assert property ((!chip_sel_low_in && !read_strobe_low_in && !strobe_is_dir_out) [*3]
         |-> ##[0:4] modes_frozen_out) else $error("modes not locked by a read");
   nonmux_cause_a:
      assert property ($rose(bus_is_nonmux_out) |-> $past(lowest_address_line_in)
         || $past(lowest_address_line_in, 2)) else $error("bus style set without address");
   oe_on_read_a:
      assert property (!chip_sel_low_in && (strobe_is_dir_out ? read_strobe_low_in
         && !data_strobe_low_in : !read_strobe_low_in) |-> data_oe_out)
         else $error("data not driven during read");
   oe_off_a:
      assert property (chip_sel_low_in |-> !data_oe_out) else $error("data driven unselected");
   idle_select_a:
      assert property ((data_oe_out && register_select_lines_in inside {3'h0, 3'h5, 3'h6}) [*2]
         |-> data_out == 8'h00) else $error("unmapped select reads nonzero");
   next_node_a:
      assert property ((data_oe_out && register_select_lines_in == REG_NEXT_NODE
         && $stable(next_node_in)) [*2] |-> data_out == next_node_in)
         else $error("next node value not shown");
   alert_run_a:
      assert property ($fell(line_tx_out) |-> ones_run == 8 * UNIT_CYCLES
         || ones_run == UNIT_CYCLES) else $error("mark run of wrong length");
   idle_space_a:
      assert property (!nak_busy_out && !$past(nak_busy_out) |-> !line_tx_out)
         else $error("line not at space while idle");
   frame_length_a:
      assert property ($fell(nak_busy_out) |-> busy_run >= FRAME_UNITS * UNIT_CYCLES
         && busy_run <= FRAME_UNITS * UNIT_CYCLES + 1) else $error("frame of wrong length");
   // Main scenarios
   cover property (modes_frozen_out && bus_is_nonmux_out);
   cover property (modes_frozen_out && strobe_is_dir_out);
   cover property ($fell(nak_busy_out));
endmodule : hbi_top_props
`default_nettype wire

/* File: tb/hbi_host_model.sv */
// Purpose: Microcontroller on the far side of the host port.
// Assumes: Pins change 1 ns after a rising edge.
// Notes: Released select, address and data lines show the inverse of their last value; select and strobes go high.
`timescale 1ns/10ps
`default_nettype none
module hbi_host_model (
   input wire logic clock_in, // Clock
   input wire logic [7:0] read_data_in, // Device read data
   output logic chip_sel_low_out, // Select
   output logic read_strobe_low_out, // Read or direction
   output logic write_strobe_low_out, // Write
   output logic data_strobe_low_out, // Data strobe
   output logic lowest_address_line_out, // Address bit 0
   output logic [2:0] select_out, // Select lines
   output logic [7:0] write_data_out // Write data, 8 bits
);
   // ************************************************************
   // Bus cycles
   // ************************************************************
   // Idle bus at time zero
   initial begin
      chip_sel_low_out = 1'b1;
      read_strobe_low_out = 1'b1;
      write_strobe_low_out = 1'b1;
      data_strobe_low_out = 1'b1;
      lowest_address_line_out = 1'b0;
      select_out = 3'h0;
      write_data_out = 8'h00;
   end
   // One access, held for fixed cycles since there is no ready line
   task automatic access(input logic rd, input logic dir, input logic cs,
      input logic [2:0] sel, input logic a0, input logic [7:0] wd, output logic [7:0] rq);
      @(posedge clock_in);
      #1;
      chip_sel_low_out = ~cs;
      select_out = sel;
      lowest_address_line_out = a0;
      write_data_out = wd;
      read_strobe_low_out = dir ? rd : ~rd;
      write_strobe_low_out = dir | rd;
      data_strobe_low_out = ~dir;
      // Stretched strobe covers the fast read delays
      repeat (6) @(posedge clock_in);
      rq = read_data_in;
      #1;
      chip_sel_low_out = 1'b1;
      read_strobe_low_out = 1'b1;
      write_strobe_low_out = 1'b1;
      data_strobe_low_out = 1'b1;
      select_out = ~sel;
      lowest_address_line_out = ~a0;
      write_data_out = ~wd;
      repeat (3) @(posedge clock_in);
   endtask : access
endmodule : hbi_host_model
`default_nettype wire

/* File: tb/hbi_top_test.sv */
// Purpose: Self-checking bench for the host bus port.
// Assumes: Inputs change 1 ns after a rising edge.
// Notes: Separate strobes first, then direction style after a reset.
`timescale 1ns/10ps
`default_nettype none
module hbi_top_test;
   import hbi_pkg::*;
   // ************************************************************
   // Pins, counters and helpers
   // ************************************************************
   logic clock_in = 1'b0; // Clock
   logic rst_in = 1'b1; // Reset
   logic fast_read_select_in = 1'b0; // Fast read
   logic nak_request_in = 1'b0; // Frame request
   logic [7:0] diagnostic_status_event_in = 8'h00; // Events
   logic [7:0] next_node_in = 8'h5A; // Next node
   logic cs_low, rd_low, wr_low, ds_low, addr0; // Host control
   logic [2:0] sel; // Select lines
   logic [7:0] wdata, rdata, got; // Data
   logic oe, line_tx, nak_busy, is_dir, is_nonmux, frozen; // Outputs
   logic dir = 1'b0; // Host uses direction style
   logic a0_on = 1'b1; // Host shows address bit 0
   int errors = 0;
   int num_checks = 0;
   int cycles = 0;
   always #20 clock_in = ~clock_in;
   // Cut a hang short
   always @(posedge clock_in) begin
      cycles = cycles + 1;
      if (cycles == 2000) begin
         errors = errors + 1;
         stop_test();
      end
   end
   hbi_host_model u_host (.clock_in(clock_in), .read_data_in(rdata),
      .chip_sel_low_out(cs_low), .read_strobe_low_out(rd_low), .write_strobe_low_out(wr_low),
      .data_strobe_low_out(ds_low), .lowest_address_line_out(addr0), .select_out(sel),
      .write_data_out(wdata));
   hbi_top u_dut (.clock_in(clock_in), .rst_in(rst_in), .chip_sel_low_in(cs_low),
      .read_strobe_low_in(rd_low), .write_strobe_low_in(wr_low), .data_strobe_low_in(ds_low),
      .lowest_address_line_in(addr0), .register_select_lines_in(sel), .data_in(wdata),
      .data_out(rdata), .data_oe_out(oe), .fast_read_select_in(fast_read_select_in),
      .diagnostic_status_event_in(diagnostic_status_event_in), .next_node_in(next_node_in),
      .nak_request_in(nak_request_in), .line_tx_out(line_tx), .nak_busy_out(nak_busy),
      .strobe_is_dir_out(is_dir), .bus_is_nonmux_out(is_nonmux), .modes_frozen_out(frozen));
   // Compare and count
   task automatic check(input string what, input logic [7:0] exp, input logic [7:0] seen);
      num_checks = num_checks + 1;
      if (seen !== exp) begin
         errors = errors + 1;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   // Report and end the run
   task automatic stop_test();
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : stop_test
   task automatic wr(input logic [2:0] s, input logic [7:0] d);
      u_host.access(1'b0, dir, 1'b1, s, s[0] & a0_on, d, got);
   endtask : wr
   task automatic rd(input string what, input logic [2:0] s, input logic [7:0] exp);
      u_host.access(1'b1, dir, 1'b1, s, s[0] & a0_on, 8'h00, got);
      check(what, exp, got);
   endtask : rd
   // One cycle of event bits into the diagnostic status
   task automatic pulse_diagnostic_status(input logic [7:0] v);
      @(posedge clock_in);
      #1 diagnostic_status_event_in = v;
      @(posedge clock_in);
      #1 diagnostic_status_event_in = 8'h00;
   endtask : pulse_diagnostic_status
   // Request a refusal frame and sample each unit in its middle
   task automatic frame_check();
      logic [16:0] bits;
      bits = {8'hFF, 1'b0, 8'h15};
      @(posedge clock_in);
      #1 nak_request_in = 1'b1;
      @(posedge clock_in);
      #1 nak_request_in = 1'b0;
      repeat (3) @(posedge clock_in);
      #2;
      for (int k = 16; k >= 0; k--) begin
         check("line bit", {7'h00, bits[k]}, {7'h00, line_tx});
         repeat (UNIT_CYCLES) @(posedge clock_in);
         #2;
      end
      check("line idle", 8'h00, {6'h00, nak_busy, line_tx});
   endtask : frame_check
   // ************************************************************
   // Main sequence
   // ************************************************************
   initial begin
      repeat (6) @(posedge clock_in);
      #1 rst_in = 1'b0;
      check("modes", 8'h00, {5'h00, is_dir, is_nonmux, frozen});
      check("line", 8'h00, {7'h00, line_tx});
      wr(REG_PTR_LO, 8'h00);
      rd("next node", REG_NEXT_NODE, 8'h5A);
      check("modes", 8'h03, {5'h00, is_dir, is_nonmux, frozen});
      u_host.access(1'b0, 1'b1, 1'b0, 3'h1, 1'b0, 8'h33, got);
      check("modes", 8'h03, {5'h00, is_dir, is_nonmux, frozen});
      wr(REG_PTR_HI, 8'h45);
      wr(REG_PTR_LO, 8'hFE);
      for (int i = 0; i < 3; i++) wr(REG_DATA, 8'(8'hA0 + i));
      wr(REG_PTR_HI, 8'hC5);
      wr(REG_PTR_LO, 8'hFE);
      rd("ram", REG_DATA, 8'hA0);
      rd("ram again", REG_DATA, 8'hA0);
      wr(REG_PTR_HI, 8'hC5);
      wr(REG_PTR_LO, 8'hFF);
      rd("ram next", REG_DATA, 8'hA1);
      wr(REG_PTR_HI, 8'h86);
      wr(REG_PTR_LO, 8'h00);
      rd("ram carry", REG_DATA, 8'hA2);
      pulse_diagnostic_status(8'h24);
      rd("diagnostic_status", REG_DIAGNOSTIC_STATUS, 8'h24);
      rd("diagnostic_status clear", REG_DIAGNOSTIC_STATUS, 8'h00);
      wr(3'h5, 8'hFF);
      rd("unmapped", 3'h5, 8'h00);
      @(posedge clock_in);
      #1 fast_read_select_in = 1'b1;
      pulse_diagnostic_status(8'h81);
      rd("fast diagnostic_status", REG_DIAGNOSTIC_STATUS, 8'h81);
      rd("fast clear", REG_DIAGNOSTIC_STATUS, 8'h00);
      wr(REG_PTR_HI, 8'hC5);
      wr(REG_PTR_LO, 8'hFF);
      rd("fast ram", REG_DATA, 8'hA1);
      rd("fast node", REG_NEXT_NODE, 8'h5A);
      frame_check();
      @(posedge clock_in);
      #1 rst_in = 1'b1;
      repeat (6) @(posedge clock_in);
      #1 rst_in = 1'b0;
      check("modes", 8'h00, {5'h00, is_dir, is_nonmux, frozen});
      dir = 1'b1;
      a0_on = 1'b0;
      u_host.access(1'b0, 1'b1, 1'b0, 3'h1, 1'b0, 8'h33, got);
      rd("dir node", REG_NEXT_NODE, 8'h5A);
      check("modes", 8'h05, {5'h00, is_dir, is_nonmux, frozen});
      stop_test();
   end
endmodule : hbi_top_test
bind hbi_top hbi_top_props u_props (.*);
`default_nettype wire
